/* hdl/secf_access_flags.sv */
// Secure card access flags: code check, attempt counter, zone gating, Avalon-MM slave
`timescale 1ns/1ps
module secf_access_flags (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        card_step_i,
  input  wire logic        card_addr_reset_i,
  input  wire logic        card_prog_i,
  input  wire logic        io_i,
  output logic             io_o,
  output logic             io_oe_o,
  output logic             zone_read_ok_o,
  output logic             zone_write_ok_o,
  output logic [4:0]       flags_o,
  output logic             locked_o,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  // ****************************************
  // Pin synchronisation and event decode
  // ****************************************
  secf_pkg::secf_pins_t pins_raw;
  secf_pkg::secf_pins_t pins_s;
  logic                 step_prev_r;

  assign pins_raw = '{addr_reset: card_addr_reset_i, step: card_step_i, prog: card_prog_i, data: io_i};

  secf_sync #(
    .WIDTH ($bits(secf_pkg::secf_pins_t))
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (pins_raw),
    .sync_o  (pins_s)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      step_prev_r <= 1'b0;
    end else if (ce_i) begin
      step_prev_r <= pins_s.step;
    end
  end

  // Address reset dominates; programming edges do not advance the address
  wire step_rise = pins_s.step && !step_prev_r && !pins_s.addr_reset;
  wire ev_step   = step_rise && !pins_s.prog;
  wire ev_write  = step_rise && pins_s.prog && !pins_s.data;
  wire ev_erase  = step_rise && pins_s.prog && pins_s.data;

  // ****************************************
  // State
  // ****************************************
  secf_pkg::secf_addr_t       addr_r;
  secf_pkg::secf_addr_t       addr_nxt;
  logic [secf_pkg::CODE_W-1:0] code_r;
  logic [secf_pkg::ATT_W-1:0]  att_r;
  logic [secf_pkg::ATT_W-1:0]  att_nxt;
  logic [3:0]                  zone_ctl_r;
  logic [3:0]                  zone_ctl_nxt;
  logic                        mode2_r;
  logic                        mismatch_r;
  logic                        mismatch_nxt;
  logic                        result_r;
  logic                        result_nxt;
  logic                        rvalid_r;
  logic                        rvalid_nxt;
  secf_pkg::secf_seq_t         seq_r;
  secf_pkg::secf_seq_t         seq_nxt;
  secf_pkg::secf_flags_t       flags;

  // ****************************************
  // Address decode
  // ****************************************
  wire [3:0] code_idx  = 4'(addr_r - secf_pkg::CODE_FIRST);
  wire [3:0] att_idx   = 4'(addr_r - secf_pkg::ATT_FIRST);
  wire in_code         = addr_r >= secf_pkg::CODE_FIRST && addr_r <= secf_pkg::CODE_LAST;
  wire in_try          = addr_r >= secf_pkg::ATT_FIRST && addr_r <= secf_pkg::ATT_TRY_LAST;
  wire in_att          = addr_r >= secf_pkg::ATT_FIRST && addr_r <= secf_pkg::ATT_LAST;
  wire in_z1           = addr_r >= secf_pkg::Z1_FIRST && addr_r <= secf_pkg::Z1_LAST;
  wire in_z2           = addr_r >= secf_pkg::Z2_FIRST && addr_r <= secf_pkg::Z2_LAST;
  wire at_z1w          = addr_r == secf_pkg::Z1W_BIT;
  wire at_z1r          = addr_r == secf_pkg::Z1R_BIT;
  wire at_z2w          = addr_r == secf_pkg::Z2W_BIT;
  wire at_z2r          = addr_r == secf_pkg::Z2R_BIT;
  wire locked          = att_r[secf_pkg::ATT_TRIES-1:0] == '0;
  wire code_bit_bad    = pins_s.data != code_r[code_idx];

  // ****************************************
  // Access permissions
  // ****************************************
  wire z1_wr_ok = mode2_r ? (flags.zone_one_write_flag && flags.security_pass_flag)
                          : flags.security_pass_flag;
  wire z2_wr_ok = mode2_r ? (flags.zone_two_write_flag && flags.security_pass_flag)
                          : flags.security_pass_flag;
  wire z1_rd_ok = flags.zone_one_read_flag || flags.security_pass_flag;
  wire z2_rd_ok = flags.zone_two_read_flag || flags.security_pass_flag;
  wire rd_ok    = in_z1 ? z1_rd_ok : (in_z2 ? z2_rd_ok : 1'b1);
  wire wr_ok    = in_z1 ? z1_wr_ok : (in_z2 ? z2_wr_ok : 1'b0);

  // Zone control bits live inside the zones, so the same gating covers them
  wire [3:0] zone_sel = {at_z2r, at_z2w, at_z1r, at_z1w};
  // Code bits stay hidden until the pass flag is up
  wire data_bit = in_code ? (flags.security_pass_flag && code_r[code_idx]) :
                  in_att  ? att_r[att_idx] :
                  (|zone_sel) ? (rd_ok && |(zone_ctl_r & zone_sel)) : 1'b0;

  // ****************************************
  // Flags
  // ****************************************
  wire valid_erase = ev_erase && seq_r == secf_pkg::SEQ_WRITTEN && in_try;
  wire pass_ok     = valid_erase && !mismatch_r && !locked;
  logic [4:0] flag_set;

  assign flag_set[0] = pass_ok;
  assign flag_set[1] = at_z1w && zone_ctl_r[0];
  assign flag_set[2] = at_z1r && zone_ctl_r[1];
  assign flag_set[3] = at_z2w && zone_ctl_r[2];
  assign flag_set[4] = at_z2r && zone_ctl_r[3];

  // Reset only clears these; nothing else can
  for (genvar g = 0; g < secf_pkg::FLAG_N; g++) begin : g_flag
    secf_sticky u_flag (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .set_i   (flag_set[g]),
      .flag_o  (flags[g])
    );
  end

  // ****************************************
  // Code check and validation sequence
  // ****************************************
  always_comb begin
    seq_nxt      = seq_r;
    mismatch_nxt = mismatch_r;
    result_nxt   = result_r;
    rvalid_nxt   = rvalid_r;
    addr_nxt     = addr_r;
    att_nxt      = att_r;
    zone_ctl_nxt = zone_ctl_r;
    if (pins_s.addr_reset) begin
      addr_nxt   = '0;
      seq_nxt    = secf_pkg::SEQ_IDLE;
      rvalid_nxt = 1'b0;
    end else if (ev_step) begin
      addr_nxt   = addr_r + 11'h001;
      rvalid_nxt = 1'b0;
      case (seq_r)
        secf_pkg::SEQ_IDLE: begin
          if (addr_r == secf_pkg::CODE_FIRST) begin
            seq_nxt      = secf_pkg::SEQ_CODE;
            mismatch_nxt = code_bit_bad;
          end
        end
        secf_pkg::SEQ_CODE: begin
          mismatch_nxt = mismatch_r || code_bit_bad;
          if (addr_r == secf_pkg::CODE_LAST) begin
            seq_nxt = secf_pkg::SEQ_READY;
          end
        end
        secf_pkg::SEQ_READY: begin
          // Searching for a 1 is allowed only inside the try bits
          if (!in_try || addr_r == secf_pkg::ATT_TRY_LAST) begin
            seq_nxt = secf_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_nxt = secf_pkg::SEQ_IDLE;
        end
      endcase
    end else if (ev_write) begin
      if (in_att) begin
        att_nxt[att_idx] = 1'b0;
      end
      if (wr_ok) begin
        zone_ctl_nxt = zone_ctl_r & ~zone_sel;
      end
      if (seq_r == secf_pkg::SEQ_READY && in_try && att_r[att_idx]) begin
        seq_nxt = secf_pkg::SEQ_WRITTEN;
      end else begin
        seq_nxt = secf_pkg::SEQ_IDLE;
      end
    end else if (ev_erase) begin
      seq_nxt    = secf_pkg::SEQ_IDLE;
      result_nxt = pass_ok;
      rvalid_nxt = in_att;
      if (pass_ok) begin
        att_nxt = secf_pkg::ATT_RST;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seq_r      <= secf_pkg::SEQ_IDLE;
      mismatch_r <= 1'b0;
      result_r   <= 1'b0;
      rvalid_r   <= 1'b0;
      addr_r     <= '0;
    end else if (ce_i) begin
      seq_r      <= seq_nxt;
      mismatch_r <= mismatch_nxt;
      result_r   <= result_nxt;
      rvalid_r   <= rvalid_nxt;
      addr_r     <= addr_nxt;
    end
  end

  // ****************************************
  // Avalon-MM slave, one wait state
  // ****************************************
  logic [31:0] rdata_nxt;
  wire         bus_req  = avs_read_i || avs_write_i;
  wire         bus_wr   = avs_write_i && !avs_waitrequest_o;
  wire [31:0]  be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire         wr_ctrl  = bus_wr && avs_address_i == secf_pkg::REG_CTRL;
  wire         wr_code  = bus_wr && avs_address_i == secf_pkg::REG_CODE;
  wire         wr_att   = bus_wr && avs_address_i == secf_pkg::REG_ATTEMPT;
  wire         wr_zone  = bus_wr && avs_address_i == secf_pkg::REG_ZONE;
  wire [31:0]  wmask    = avs_writedata_i & be_mask;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_i)
      secf_pkg::REG_CTRL:    rdata_nxt[0]     = mode2_r;
      secf_pkg::REG_CODE:    rdata_nxt[15:0]  = code_r;
      secf_pkg::REG_ATTEMPT: rdata_nxt[15:0]  = att_r;
      secf_pkg::REG_ZONE:    rdata_nxt[3:0]   = zone_ctl_r;
      secf_pkg::REG_STATUS: begin
        rdata_nxt[secf_pkg::ST_FLAGS +: 5]              = flags;
        rdata_nxt[secf_pkg::ST_LOCKED]                  = locked;
        rdata_nxt[secf_pkg::ST_RESULT]                  = result_r;
        rdata_nxt[secf_pkg::ST_RVALID]                  = rvalid_r;
        rdata_nxt[secf_pkg::ST_ADDR +: secf_pkg::ADDR_W] = addr_r;
      end
      default:               rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Bus writes land after card updates; software owns personalisation
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      mode2_r           <= secf_pkg::MODE_RST;
      code_r            <= secf_pkg::CODE_RST;
      att_r             <= secf_pkg::ATT_RST;
      zone_ctl_r        <= secf_pkg::ZONE_RST;
    end else if (ce_i) begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
      if (bus_req && avs_waitrequest_o) begin
        avs_readdata_o <= rdata_nxt;
      end
      mode2_r    <= (wr_ctrl && avs_byteenable_i[0]) ? avs_writedata_i[0] : mode2_r;
      code_r     <= wr_code ? ((code_r & ~be_mask[15:0]) | wmask[15:0]) : code_r;
      att_r      <= wr_att ? ((att_nxt & ~be_mask[15:0]) | wmask[15:0]) : att_nxt;
      zone_ctl_r <= (wr_zone && avs_byteenable_i[0]) ? avs_writedata_i[3:0] : zone_ctl_nxt;
    end
  end

  // ****************************************
  // Card side outputs
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      io_o            <= 1'b0;
      io_oe_o         <= 1'b0;
      zone_read_ok_o  <= 1'b0;
      zone_write_ok_o <= 1'b0;
      flags_o         <= '0;
      locked_o        <= 1'b0;
    end else if (ce_i) begin
      io_o            <= rvalid_r ? result_r : data_bit;
      io_oe_o         <= !pins_s.prog;
      zone_read_ok_o  <= rd_ok;
      zone_write_ok_o <= wr_ok;
      flags_o         <= flags;
      locked_o        <= locked;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_code_done;
    ce_i && ev_step && seq_r == secf_pkg::SEQ_CODE && addr_r == secf_pkg::CODE_LAST;
  endsequence

  sequence s_good_erase;
    ce_i && valid_erase && !mismatch_r && !locked;
  endsequence

  chk_code_to_ready: assert property (s_code_done |=> seq_r == secf_pkg::SEQ_READY)
    else $error("Code compare did not finish at address 95");
  chk_pass_success: assert property (s_good_erase |=> flags.security_pass_flag && att_r == secf_pkg::ATT_RST)
    else $error("Good validation did not set pass flag and restore counter");
  chk_io_shows_one: assert property (s_good_erase ##1 ce_i |=> io_o && rvalid_r)
    else $error("Data line did not show 1 after good validation");
  chk_fail_no_pass: assert property (ce_i && ev_erase && (mismatch_r || locked) && !flags.security_pass_flag
                                     |=> !flags.security_pass_flag && !result_r)
    else $error("Failed validation set the pass flag");
  chk_pass_holds: assert property (flags.security_pass_flag |=> flags.security_pass_flag)
    else $error("Pass flag dropped without reset");
  chk_flags_hold: assert property ((flags & $past(flags)) == $past(flags))
    else $error("A zone flag dropped without reset");
  chk_z1w_sets: assert property (ce_i && at_z1w && zone_ctl_r[0] |=> flags.zone_one_write_flag)
    else $error("Zone one write flag not set at its address");
  chk_z2r_sets: assert property (ce_i && at_z2r && zone_ctl_r[3] |=> flags.zone_two_read_flag)
    else $error("Zone two read flag not set at its address");
  chk_z1_wr_gate: assert property (ce_i && in_z1 && mode2_r |=>
                                   zone_write_ok_o == $past(flags.zone_one_write_flag && flags.security_pass_flag))
    else $error("Zone one write gate wrong in mode 2");
  chk_z2_rd_gate: assert property (ce_i && in_z2 |=>
                                   zone_read_ok_o == $past(flags.zone_two_read_flag || flags.security_pass_flag))
    else $error("Zone two read gate wrong");
  chk_lock_blocks: assert property (ce_i && locked && !flags.security_pass_flag |=> !flags.security_pass_flag)
    else $error("Locked card gained the pass flag");
  chk_bus_answer: assert property (ce_i && bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Bus request not answered after one wait state");

endmodule

/* hdl/secf_pkg.sv */
// Constants, carriers and states for the secure card access flag block
package secf_pkg;

  localparam int ADDR_W = 11;
  localparam int CODE_W = 16;
  localparam int ATT_W  = 16;
  localparam int FLAG_N = 5;

  typedef logic [ADDR_W-1:0] secf_addr_t;

  // ****************************************
  // Card bit addresses
  // ****************************************
  localparam secf_addr_t CODE_FIRST   = 11'h050;
  localparam secf_addr_t CODE_LAST    = 11'h05F;
  localparam secf_addr_t ATT_FIRST    = 11'h060;
  localparam secf_addr_t ATT_TRY_LAST = 11'h067;
  localparam secf_addr_t ATT_LAST     = 11'h06F;
  localparam secf_addr_t Z1W_BIT      = 11'h0B0;
  localparam secf_addr_t Z1R_BIT      = 11'h0B1;
  localparam secf_addr_t Z1_FIRST     = 11'h0B0;
  localparam secf_addr_t Z1_LAST      = 11'h2AF;
  localparam secf_addr_t Z2W_BIT      = 11'h2E0;
  localparam secf_addr_t Z2R_BIT      = 11'h2E1;
  localparam secf_addr_t Z2_FIRST     = 11'h2E0;
  localparam secf_addr_t Z2_LAST      = 11'h4DF;
  localparam int         ATT_TRIES    = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CODE_W-1:0] CODE_RST = 16'hFFFF;
  localparam logic [ATT_W-1:0]  ATT_RST  = 16'hFFFF;
  localparam logic [3:0]        ZONE_RST = 4'h0;
  localparam logic              MODE_RST = 1'h0;

  // ****************************************
  // Register map and status layout
  // ****************************************
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_CODE    = 5'h04;
  localparam logic [4:0] REG_ATTEMPT = 5'h08;
  localparam logic [4:0] REG_ZONE    = 5'h0C;
  localparam logic [4:0] REG_STATUS  = 5'h10;
  localparam int ST_FLAGS  = 0;
  localparam int ST_LOCKED = 5;
  localparam int ST_RESULT = 6;
  localparam int ST_RVALID = 7;
  localparam int ST_ADDR   = 16;

  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic addr_reset;
    logic step;
    logic prog;
    logic data;
  } secf_pins_t;

  typedef struct packed {
    logic zone_two_read_flag;
    logic zone_two_write_flag;
    logic zone_one_read_flag;
    logic zone_one_write_flag;
    logic security_pass_flag;
  } secf_flags_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CODE,
    SEQ_READY,
    SEQ_WRITTEN
  } secf_seq_t;

endpackage

/* hdl/secf_sync.sv */
// Two-stage synchroniser for card pins
`timescale 1ns/1ps
module secf_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

/* hdl/secf_sticky.sv */
// Power-held flag: set by an event, cleared only by reset
`timescale 1ns/1ps
module secf_sticky (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  output logic      flag_o
);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (ce_i && set_i) begin
      flag_o <= 1'b1;
    end
  end
endmodule

/* testbench/secf_reader.sv */
// Card reader model driving the card pins of the access flag block
`timescale 1ns/1ps
module secf_reader (
  input  wire logic clock_i,
  output logic      step_o,
  output logic      addr_reset_o,
  output logic      prog_o,
  output logic      io_o,
  output logic      io_en_o
);
  int addr = 0;

  initial begin
    {step_o, addr_reset_o, prog_o, io_o, io_en_o} = 5'h00;
  end

  // ****************************************
  // Pin sequences
  // ****************************************
  // Three clocks per level so both sync flops see every change
  task automatic hold();
    repeat (3) @(posedge clock_i);
  endtask

  task automatic tick(input logic p, input logic e, input logic d);
    prog_o  <= p;
    io_en_o <= e;
    io_o    <= d;
    hold();
    step_o <= 1'b1;
    hold();
    step_o <= 1'b0;
    hold();
    if (!p) addr++;
  endtask

  task automatic addr_clear();
    addr_reset_o <= 1'b1;
    hold();
    addr_reset_o <= 1'b0;
    hold();
    addr = 0;
  endtask

  task automatic go_to(input int a);
    while (addr < a) tick(1'b0, 1'b0, io_o);
  endtask

  task automatic present(input logic [15:0] code);
    addr_clear();
    go_to(80);
    for (int i = 0; i < 16; i++) tick(1'b0, 1'b1, code[i]);
  endtask

  // Write then erase with no step between; a step there would void the try
  task automatic validate(input int a);
    go_to(a);
    tick(1'b1, 1'b1, 1'b0);
    tick(1'b1, 1'b1, 1'b1);
    prog_o  <= 1'b0;
    io_en_o <= 1'b0;
    repeat (3) hold();
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the secure card access flag block
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] CODE = 16'h5A3C;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [4:0]  av_addr = 5'h00;
  logic        av_rd   = 1'b0;
  logic        av_wr   = 1'b0;
  logic [31:0] av_wd   = 32'h0;
  logic [3:0]  av_be   = 4'hF;
  logic        ce      = 1'b1;
  logic [31:0] av_rdata;
  logic [31:0] rdata;
  logic        io_o, io_oe_o, read_ok, write_ok, locked, waitreq;
  logic [4:0]  flags;
  logic        step, areset, prog, rd_io, rd_en;
  int          fails   = 0;
  int          n_tests = 0;
  // Released line shows the inverse of its last level, never a stale match
  wire logic   io_line = rd_en ? rd_io : (io_oe_o ? io_o : ~rd_io);

  always #12.5 clock_i = ~clock_i;

  secf_reader rdr_u (.clock_i(clock_i), .step_o(step), .addr_reset_o(areset), .prog_o(prog),
                     .io_o(rd_io), .io_en_o(rd_en));

  secf_access_flags dut_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .card_step_i(step),
    .card_addr_reset_i(areset), .card_prog_i(prog), .io_i(io_line), .io_o(io_o), .io_oe_o(io_oe_o),
    .zone_read_ok_o(read_ok), .zone_write_ok_o(write_ok), .flags_o(flags), .locked_o(locked),
    .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
    .avs_byteenable_i(av_be), .avs_readdata_o(av_rdata), .avs_waitrequest_o(waitreq));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    av_addr <= a;
    av_wd   <= d;
    av_wr   <= w;
    av_rd   <= !w;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clock_i);
    end while (waitreq !== 1'b0);
    rdata = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic rd_check(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rdata, exp, what);
  endtask

  task automatic power_up();
    rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    power_up();
    rd_check(secf_pkg::REG_CTRL, 32'h0, "ctrl");
    rd_check(secf_pkg::REG_CODE, 32'h0000FFFF, "code");
    rd_check(secf_pkg::REG_ATTEMPT, 32'h0000FFFF, "attempts");
    rd_check(secf_pkg::REG_ZONE, 32'h0, "zone bits");
    rd_check(5'h14, 32'h0, "unmapped");
    check({27'h0, flags}, 32'h0, "flags at power-on");
    // Only the low byte lane may land
    av_be <= 4'h1;
    bus(1'b1, secf_pkg::REG_CODE, 32'h0000_1234);
    av_be <= 4'hF;
    rd_check(secf_pkg::REG_CODE, 32'h0000FF34, "code low byte only");
    $display("test reset done");
    bus(1'b1, secf_pkg::REG_CODE, {16'h0, CODE});
    bus(1'b1, secf_pkg::REG_CTRL, 32'h1);
    rdr_u.present(~CODE);
    rdr_u.validate(96);
    check(io_o, 1'b0, "io after bad code");
    check(io_oe_o, 1'b1, "data line driven after prog");
    check({27'h0, flags}, 32'h0, "flags after bad code");
    rd_check(secf_pkg::REG_ATTEMPT, 32'h0000FFFE, "one try used");
    rdr_u.go_to(180);
    repeat (8) @(posedge clock_i);
    check(read_ok, 1'b0, "zone one read locked");
    check(write_ok, 1'b0, "zone one write locked");
    $display("test bad code done");
    rdr_u.present(CODE);
    rdr_u.validate(97);
    check(io_o, 1'b1, "io after good code");
    check(flags[0], 1'b1, "pass flag");
    rd_check(secf_pkg::REG_ATTEMPT, 32'h0000FFFF, "tries restored");
    rdr_u.go_to(180);
    repeat (8) @(posedge clock_i);
    check(read_ok, 1'b1, "zone one read by pass");
    check(write_ok, 1'b0, "mode two needs write flag");
    $display("test good code done");
    bus(1'b1, secf_pkg::REG_ZONE, 32'hF);
    rdr_u.addr_clear();
    rdr_u.go_to(178);
    repeat (8) @(posedge clock_i);
    check({27'h0, flags}, 32'h07, "zone one flags");
    check(write_ok, 1'b1, "zone one write");
    // Source bits of zone one go to 0; its flags must not follow
    bus(1'b1, secf_pkg::REG_ZONE, 32'hC);
    rdr_u.go_to(738);
    repeat (8) @(posedge clock_i);
    check({27'h0, flags}, 32'h1F, "all flags");
    check(write_ok, 1'b1, "zone two write");
    check(read_ok, 1'b1, "zone two read");
    // A step while the enable is low must be lost: address stays at 738
    ce <= 1'b0;
    rdr_u.tick(1'b0, 1'b0, 1'b0);
    ce <= 1'b1;
    rd_check(secf_pkg::REG_STATUS, 32'h02E2005F, "frozen step ignored");
    $display("test zone flags done");
    power_up();
    check({27'h0, flags}, 32'h0, "flags after power cycle");
    bus(1'b1, secf_pkg::REG_CODE, {16'h0, CODE});
    for (int i = 0; i < 8; i++) begin
      rdr_u.present(~CODE);
      rdr_u.validate(96 + i);
    end
    check(locked, 1'b1, "locked after eight");
    rdr_u.present(CODE);
    rdr_u.validate(103);
    check(io_o, 1'b0, "locked card refuses");
    check(flags[0], 1'b0, "no pass when locked");
    $display("test lockout done");
    print_verdict();
  end

  // Longest path is about 18400 clocks; allow over three times that
  initial begin
    #1500000;
    fails++;
    print_verdict();
  end
endmodule
